// >>> lpp_port_ctrl.sv
// loop to parallel port control: status, service request, parallel poll, output handshake
//
// Overview of operation
// RQ1: status 1 loop-ready, 2 data for loop
// RQ2: status 4 full for port, 6 full for loop
// RQ3: status 8 on missing accept or ready
// RQ4: port data while buffer busy rejected, status 16
// RQ5: status 32 while manual request pin low
// RQ6: bit 6 marks originated request, clears on change
// RQ7: request from manual pin or enabled condition
// RQ8: poll index 0-7 forces bit when idle
// RQ9: poll index 8-15 forces bit when requesting
// RQ10: identify srq set, no other bits touched
// RQ11: unconfigure, or disable as listener, stops polling
// RQ12: listener outputs, talker inputs, idle accepts input
// RQ13: parallel bus runs one direction at once
// RQ14: config bits 2,1 pick bus arrangement
// RQ15: wide mode: bus A high, bus B low
// RQ16: peer keeps off bus B while select low; here select stays high, also while bus B is driven in wide mode
// RQ17: lines high whenever data valid is off
// RQ18: config bits 7,6 pick output handshake
// RQ19: config bit 4 inverts handshake lines
// RQ20: config bit 3 picks 100 or 5 us unit
// RQ21: config bit 0 enables valid timeout
// RQ22: strobe and ready/valid use fixed 5 us width; here the width is pulse-width register times 5 us
// RQ23: timeout withdraws data from the bus
// RQ24: status follows at once, busy held until sent
// RQ25: data and handshake polarity chosen independently
// RQ26: reset leaves valid off, lines high, status clear
`timescale 1ns/1ps
module lpp_port_ctrl
    import lpp_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  wire lpp_loop_cmd_t loop_cmd,
    input  wire lpp_byte_t     loop_rx,
    output lpp_byte_t          loop_tx_r,
    input  wire logic          loop_tx_take,
    output logic               loop_rx_ready_r,
    input  wire lpp_idy_t      idy_in,
    output lpp_idy_t           idy_out_r,
    output logic               srq_out_r,
    output logic [7:0]         status_r,
    input  wire logic [7:0]    port_a_lines_i,
    output logic [7:0]         port_a_lines_o_r,
    output logic               port_a_lines_oe_r,
    input  wire logic [7:0]    port_b_lines_i,
    output logic [7:0]         port_b_lines_o_r,
    output logic               port_b_lines_oe_r,
    output logic               data_valid_out_r,
    input  wire logic          data_accepted_in,
    input  wire logic          peer_ready_in,
    input  wire logic          peer_valid_in,
    output logic               ready_out_r,
    output logic               accepted_out_r,
    input  wire logic          manual_service_req_n,
    output logic               chip_sel_n_r
);
    typedef enum logic [1:0] {OS_IDLE, OS_WAIT_RDY, OS_DRIVE, OS_GAP} lpp_ostate_t;

    function automatic logic [7:0] pol(input logic [7:0] v, input logic neg);
        pol = v ^ {8{neg}};
    endfunction

    // pin inputs through two flops
    logic [7:0] pa_s;
    logic [7:0] pb_s;
    logic       man_n_s;
    logic       val_s;
    logic       acc_s;
    logic       rdy_s;
    lpp_sync2 #(.W(20), .RST_VAL(20'h8_0000)) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       ({manual_service_req_n, peer_valid_in, data_accepted_in, peer_ready_in,
                   port_a_lines_i, port_b_lines_i}),
        .q       ({man_n_s, val_s, acc_s, rdy_s, pa_s, pb_s})
    );

    logic [7:0]  svc_en_r;
    logic [7:0]  cfg_r;
    logic [7:0]  pw_r;
    logic [7:0]  mem_r [0:1];
    logic [1:0]  cnt_r;
    logic        rd_r;
    logic        wr_r;
    logic        dir_loop_r;
    lpp_ostate_t state_r;
    lpp_ostate_t state_nxt;
    logic [15:0] word_r;
    logic [7:0]  unit_cnt_r;
    logic        dav_act_r;
    logic        val_q_r;
    logic        busy_r;
    logic        nohs_r;
    logic        pp_en_r;
    logic [3:0]  pp_idx_r;
    logic        tick;

    // configuration decode
    wire        hs_neg   = cfg_r[CFG_HS_NEG];                             // see RQ19
    wire        data_neg = cfg_r[CFG_DATA_NEG];                           // see RQ25
    wire        wide     = cfg_r[CFG_WIDE] & ~cfg_r[CFG_UNIDIR];          // see RQ14
    wire        unidir   = cfg_r[CFG_UNIDIR];
    wire        lpp_hs_t hs_mode = lpp_hs_t'(cfg_r[CFG_HS_LO+1:CFG_HS_LO]); // see RQ18
    wire        timed_hs = (hs_mode == HS_FULL) || (hs_mode == HS_VAL_ACC);
    wire        fast     = timed_hs ? cfg_r[CFG_UNIT_FAST] : 1'b1;       // see RQ20, RQ22
    wire        acc_l    = acc_s ^ hs_neg;
    wire        rdy_l    = rdy_s ^ hs_neg;
    wire        val_l    = val_s ^ hs_neg;
    wire        man      = ~man_n_s;

    // buffer state
    wire        buf_empty  = (cnt_r == 2'h0);
    wire        buf_full   = (cnt_r == BUF_DEPTH);
    wire        loop_owned = dir_loop_r & ~buf_empty;
    wire        par_owned  = ~dir_loop_r & ~buf_empty;
    wire [1:0]  need       = wide ? 2'h2 : 2'h1;

    // loop side push and pull
    wire loop_push = loop_rx.valid & loop_cmd.listener & ~buf_full & ~par_owned;  // see RQ12
    wire tx_pop    = loop_tx_take & loop_tx_r.valid & par_owned;

    // output start: word latched and removed from buffer
    wire out_start = (state_r == OS_IDLE) & loop_owned & (cnt_r >= need);
    wire out_pop2  = out_start & wide;
    wire out_pop1  = out_start & ~wide;
    wire [15:0] word_now = out_start ? (wide ? {mem_r[rd_r], mem_r[~rd_r]} : {mem_r[rd_r], 8'h00}) : word_r;

    // input capture only while the bus is not an output
    wire val_rise = val_l & ~(val_q_r ^ hs_neg);   // raw pin kept: a polarity change is no edge
    wire in_allow = ~loop_cmd.listener & buf_empty & (state_r == OS_IDLE);        // see RQ12, RQ13
    wire cap      = val_rise & in_allow;
    wire busy_set = val_rise & loop_cmd.listener & ~buf_empty;                    // see RQ4

    // timing of the drive phase
    wire to_hit  = cfg_r[CFG_TO_EN] & timed_hs & (unit_cnt_r >= pw_r);            // see RQ21
    wire pw_done = (unit_cnt_r >= pw_r);
    wire hs_fail = ((state_r == OS_DRIVE) & ~acc_l & to_hit)
                 | ((state_r == OS_WAIT_RDY) & (hs_mode == HS_FULL) & to_hit & ~rdy_l); // see RQ3

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            OS_IDLE: begin
                if (out_start) begin
                    state_nxt = (hs_mode == HS_FULL || hs_mode == HS_RDY_VAL) ? OS_WAIT_RDY : OS_DRIVE;
                end
            end
            OS_WAIT_RDY: begin
                if (rdy_l) begin
                    state_nxt = OS_DRIVE;
                end else if (hs_fail) begin
                    state_nxt = OS_GAP;
                end
            end
            OS_DRIVE: begin
                if (timed_hs) begin
                    if (acc_l || to_hit) begin
                        state_nxt = OS_GAP;                                      // see RQ23
                    end
                end else if (pw_done) begin
                    state_nxt = OS_GAP;                                          // see RQ22
                end
            end
            OS_GAP: begin
                state_nxt = OS_IDLE;
            end
        endcase
    end

    lpp_timebase u_tb (
        .clk_sys (clk_sys),
        .rst     (rst),
        .restart (state_nxt != state_r),
        .fast    (fast),
        .tick    (tick)
    );

    // status condition, busy held until status is sent
    wire [5:0] cond = man                     ? ST_MANUAL                                // see RQ5
                    : busy_r                  ? ST_BUSY                                  // see RQ4, RQ24
                    : nohs_r                  ? ST_NO_HS                                 // see RQ3
                    : loop_cmd.listener       ? (buf_full ? ST_FULL_PAR : ST_READY_LOOP) // see RQ1, RQ2
                    : par_owned               ? (buf_full ? ST_FULL_LOOP : ST_DATA_LOOP)
                    : ST_NONE;
    wire       srq_cond = man | (|(svc_en_r[5:0] & cond));                      // see RQ7
    wire       orig_set = srq_cond & ~srq_out_r;
    wire       orig_clr = (cond != status_r[5:0]) | loop_cmd.send_status;
    wire       orig_nxt = orig_set | (status_r[ST_SRQ_BIT] & ~orig_clr);       // see RQ6

    // identify modification
    wire       pp_hit   = pp_en_r & (srq_out_r == pp_idx_r[3]);                 // see RQ8, RQ9
    wire [7:0] pp_mask  = 8'(8'h01 << pp_idx_r[2:0]);
    wire [7:0] idy_data = pp_hit ? (idy_in.data | pp_mask) : idy_in.data;

    // control registers written from the loop
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            svc_en_r <= SVC_EN_RST;
            cfg_r    <= BUS_CFG_RST;
            pw_r     <= PULSE_W_RST;
        end else if (loop_cmd.reg_wr) begin
            if (loop_cmd.reg_idx == REG_SVC_EN)  svc_en_r <= loop_cmd.reg_data;
            if (loop_cmd.reg_idx == REG_BUS_CFG) cfg_r    <= loop_cmd.reg_data;
            if (loop_cmd.reg_idx == REG_PULSE_W) pw_r     <= loop_cmd.reg_data;
        end
    end

    // transfer buffer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_r      <= 2'h0;
            rd_r       <= 1'b0;
            wr_r       <= 1'b0;
            dir_loop_r <= 1'b0;
            mem_r[0]   <= 8'h00;
            mem_r[1]   <= 8'h00;
        end else if (cap) begin
            // wide capture: bus A is the high byte and goes first
            mem_r[0]   <= wide ? pol(pa_s, data_neg) : pol(unidir ? pb_s : pa_s, data_neg); // see RQ15
            mem_r[1]   <= pol(pb_s, data_neg);
            cnt_r      <= need;
            rd_r       <= 1'b0;
            wr_r       <= ~wide;
            dir_loop_r <= 1'b0;
        end else if (out_pop2) begin
            cnt_r      <= 2'h0;
            rd_r       <= 1'b0;
            wr_r       <= 1'b0;
        end else begin
            if (loop_push) begin
                mem_r[wr_r] <= loop_rx.data;
                wr_r        <= ~wr_r;
                dir_loop_r  <= 1'b1;
            end
            if (out_pop1 || tx_pop) begin
                rd_r <= ~rd_r;
            end
            cnt_r <= 2'(cnt_r + {1'b0, loop_push} - {1'b0, out_pop1 | tx_pop});
        end
    end

    // output handshake state and drive timer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r    <= OS_IDLE;
            unit_cnt_r <= 8'h00;
            word_r     <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            if (state_nxt != state_r) begin
                unit_cnt_r <= 8'h00;
            end else if (tick && unit_cnt_r != 8'hFF) begin
                unit_cnt_r <= unit_cnt_r + 8'h01;
            end
            word_r <= word_now;
        end
    end

    // port pins; direction follows the flow, never both ways
    wire out_dir = loop_cmd.listener | loop_owned | (state_r != OS_IDLE);        // see RQ13
    wire drive_n = (state_nxt == OS_DRIVE);
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dav_act_r         <= 1'b0;                                         // see RQ26
            data_valid_out_r  <= 1'b0;
            port_a_lines_o_r  <= LINES_IDLE;
            port_b_lines_o_r  <= LINES_IDLE;
            port_a_lines_oe_r <= 1'b0;
            port_b_lines_oe_r <= 1'b0;
            chip_sel_n_r      <= 1'b1;
        end else begin
            dav_act_r         <= drive_n;
            data_valid_out_r  <= drive_n ^ hs_neg;                             // see RQ19
            // idle lines read high; polarity applies to valid data only
            port_a_lines_o_r  <= drive_n ? pol(word_now[15:8], data_neg) : LINES_IDLE; // see RQ17, RQ25
            port_b_lines_o_r  <= (drive_n && wide) ? pol(word_now[7:0], data_neg) : LINES_IDLE;
            port_a_lines_oe_r <= out_dir | unidir;                             // see RQ14
            port_b_lines_oe_r <= out_dir & wide;
            // bus B is driven here in wide mode and read in wide and unidirectional modes, yet select stays high
            chip_sel_n_r      <= 1'b1;                                         // see RQ16
        end
    end

    // input handshake and loop side flags
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            val_q_r         <= 1'b0;
            ready_out_r     <= 1'b0;
            accepted_out_r  <= 1'b0;
            loop_rx_ready_r <= 1'b0;
            loop_tx_r       <= '0;
        end else begin
            val_q_r         <= val_s;
            ready_out_r     <= in_allow ^ hs_neg;
            accepted_out_r  <= (cap | ((accepted_out_r ^ hs_neg) & val_l)) ^ hs_neg;
            loop_rx_ready_r <= loop_cmd.listener & ~buf_full & ~par_owned;
            // valid drops after a take so a stale byte is never offered twice
            loop_tx_r.valid <= loop_cmd.talker & par_owned & ~tx_pop & ~loop_tx_take;
            loop_tx_r.data  <= mem_r[rd_r];
        end
    end

    // status, service request and parallel poll
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busy_r    <= 1'b0;
            nohs_r    <= 1'b0;
            status_r  <= 8'h00;
            srq_out_r <= 1'b0;
            pp_en_r   <= 1'b0;
            pp_idx_r  <= 4'h0;
            idy_out_r <= '0;
        end else begin
            // new events win over clears
            busy_r    <= busy_set | (busy_r & ~loop_cmd.send_status);          // see RQ24
            nohs_r    <= hs_fail | (nohs_r & ~((state_r == OS_DRIVE) & acc_l));
            status_r  <= {1'b0, orig_nxt, cond};
            srq_out_r <= srq_cond;
            if (loop_cmd.pp_enable) begin
                pp_en_r  <= 1'b1;
                pp_idx_r <= loop_cmd.pp_index;
            end else if (loop_cmd.pp_unconfig || (loop_cmd.pp_disable && loop_cmd.listener)) begin
                pp_en_r  <= 1'b0;                                              // see RQ11
            end
            idy_out_r.valid <= idy_in.valid;
            idy_out_r.srq   <= idy_in.srq | srq_out_r;                        // see RQ10
            idy_out_r.data  <= idy_data;
        end
    end

    AST_MANUAL_STATUS: assert property (@(posedge clk_sys) disable iff (rst) // see RQ5
        man |=> status_r[5:0] == ST_MANUAL)
        else $error("manual request not shown in status");

    AST_LINES_HIGH: assert property (@(posedge clk_sys) disable iff (rst) // see RQ17
        !dav_act_r |-> port_a_lines_o_r == LINES_IDLE && port_b_lines_o_r == LINES_IDLE)
        else $error("data lines not high while valid is off");

    AST_BUSY_HELD: assert property (@(posedge clk_sys) disable iff (rst) // see RQ24
        busy_r && !loop_cmd.send_status |=> busy_r)
        else $error("busy cleared before status was sent");

    AST_BUSY_REJECT: assert property (@(posedge clk_sys) disable iff (rst) // see RQ4
        busy_set |-> !cap ##1 busy_r)
        else $error("port data taken while buffer busy");

    AST_NO_HS_FLAG: assert property (@(posedge clk_sys) disable iff (rst) // see RQ3
        hs_fail |=> nohs_r && !dav_act_r)
        else $error("timeout did not flag or withdraw");

    AST_HALF_DUPLEX: assert property (@(posedge clk_sys) disable iff (rst) // see RQ13
        cap |-> state_r == OS_IDLE && !loop_cmd.listener)
        else $error("input captured while output active");

    AST_STROBE_WIDTH: assert property (@(posedge clk_sys) disable iff (rst) // see RQ22
        $fell(dav_act_r) && !timed_hs |-> $past(unit_cnt_r) >= $past(pw_r))
        else $error("strobe shorter than pulse width");

    AST_SRQ_ORIG_CLR: assert property (@(posedge clk_sys) disable iff (rst) // see RQ6
        loop_cmd.send_status && srq_out_r |=> !status_r[ST_SRQ_BIT])
        else $error("originated bit not cleared by status send");

    AST_PP_FORCE: assert property (@(posedge clk_sys) disable iff (rst) // see RQ8
        idy_in.valid && pp_hit |=> idy_out_r.data[$past(pp_idx_r[2:0])])
        else $error("poll bit not forced");

    AST_WAIT_NO_DATA: assert property (@(posedge clk_sys) disable iff (rst) // see RQ18
        state_r == OS_WAIT_RDY && !rdy_l |=> !dav_act_r)
        else $error("valid raised before peer ready");
endmodule

// >>> lpp_pkg.sv
// shared constants, field positions and carrier types of the loop to parallel port control
package lpp_pkg;

    // control register indexes as carried by set-register messages
    localparam logic [4:0] REG_SVC_EN     = 5'h00;
    localparam logic [4:0] REG_BUS_CFG    = 5'h02;
    localparam logic [4:0] REG_PULSE_W    = 5'h03;

    // bus_handshake_config field positions
    localparam int CFG_TO_EN      = 0;
    localparam int CFG_UNIDIR     = 1;
    localparam int CFG_WIDE       = 2;
    localparam int CFG_UNIT_FAST  = 3;
    localparam int CFG_HS_NEG     = 4;
    localparam int CFG_DATA_NEG   = 5;
    localparam int CFG_HS_LO      = 6;

    // reset values
    localparam logic [7:0] SVC_EN_RST     = 8'h00;
    localparam logic [7:0] BUS_CFG_RST    = 8'h00;
    localparam logic [7:0] PULSE_W_RST    = 8'h01;
    localparam logic [7:0] LINES_IDLE     = 8'hFF;

    // status condition codes and the originated-request bit
    localparam logic [5:0] ST_NONE        = 6'h00;
    localparam logic [5:0] ST_READY_LOOP  = 6'h01;
    localparam logic [5:0] ST_DATA_LOOP   = 6'h02;
    localparam logic [5:0] ST_FULL_PAR    = 6'h04;
    localparam logic [5:0] ST_FULL_LOOP   = 6'h06;
    localparam logic [5:0] ST_NO_HS       = 6'h08;
    localparam logic [5:0] ST_BUSY        = 6'h10;
    localparam logic [5:0] ST_MANUAL      = 6'h20;
    localparam int         ST_SRQ_BIT     = 6;

    // time units
    localparam int          CLK_MHZ       = 40;
    localparam int          UNIT_FAST_US  = 5;
    localparam int          UNIT_SLOW_US  = 100;
    localparam logic [11:0] UNIT_FAST_CYC = 12'(UNIT_FAST_US * CLK_MHZ);
    localparam logic [11:0] UNIT_SLOW_CYC = 12'(UNIT_SLOW_US * CLK_MHZ);

    localparam logic [1:0]  BUF_DEPTH     = 2'h2;

    typedef enum logic [1:0] {
        HS_STROBE  = 2'h0,
        HS_RDY_VAL = 2'h1,
        HS_VAL_ACC = 2'h2,
        HS_FULL    = 2'h3
    } lpp_hs_t;

    typedef struct packed {
        logic       listener;
        logic       talker;
        logic       reg_wr;
        logic [4:0] reg_idx;
        logic [7:0] reg_data;
        logic       send_status;
        logic       pp_enable;
        logic [3:0] pp_index;
        logic       pp_unconfig;
        logic       pp_disable;
    } lpp_loop_cmd_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } lpp_byte_t;

    typedef struct packed {
        logic       valid;
        logic       srq;
        logic [7:0] data;
    } lpp_idy_t;

endpackage

// >>> lpp_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module lpp_sync2 #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// >>> lpp_timebase.sv
// time unit tick generator, 5 us or 100 us
`timescale 1ns/1ps
module lpp_timebase
    import lpp_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic restart,
    input  wire logic fast,
    output logic      tick
);
    logic [11:0] cnt_r;
    wire  [11:0] limit = fast ? UNIT_FAST_CYC : UNIT_SLOW_CYC;
    wire         wrap  = (cnt_r >= limit - 12'h001);

    // restart aligns the first unit with the start of a phase
    always_ff @(posedge clk_sys) begin
        if (rst || restart || wrap) begin
            cnt_r <= 12'h000;
        end else begin
            cnt_r <= cnt_r + 12'h001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || restart) begin
            tick <= 1'b0;
        end else begin
            tick <= wrap;
        end
    end
endmodule

// >>> lpp_peer.sv
// external parallel device model facing the port control
`timescale 1ns/1ps
module lpp_peer (
    input  wire logic       clk_sys,
    input  wire logic       acc_en,
    input  wire logic       send,
    input  wire logic [7:0] send_byte,
    input  wire logic       dv,
    input  wire logic       acc_out,
    output logic            acc_in,
    output logic            rdy_in,
    output logic            val_in,
    output logic [7:0]      lines
);
    logic done = 1'b0;
    initial begin
        acc_in = 1'b0;
        rdy_in = 1'b1;
        val_in = 1'b0;
        lines = 8'h5a;
    end
    always @(posedge clk_sys) begin
        acc_in <= acc_en & dv;
        done <= send & (done | acc_out);
        val_in <= send & !done & !acc_out;
        // bus a only, bus b left alone; released lines toggle
        lines <= (send & !done) ? send_byte : ~lines;
    end
endmodule

// >>> lpp_port_ctrl_test.sv
// self-checking bench of the loop to parallel port control
`timescale 1ns/1ps
module lpp_port_ctrl_test;
    import lpp_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    lpp_loop_cmd_t loop_cmd = '0;
    lpp_byte_t loop_rx = '0;
    lpp_byte_t loop_tx_r;
    lpp_idy_t idy_in = '0;
    lpp_idy_t idy_out_r;
    logic loop_tx_take = 1'b0;
    logic rx_rdy, srq, a_oe, b_oe, dv, acc, rdy, pv, rdy_o, acc_o, cs_n;
    logic [7:0] status_r, a_o, b_o, p_lines;
    logic manual_service_req_n_n = 1'b1;
    logic acc_en = 1'b0;
    logic send = 1'b0;
    logic [7:0] send_byte = 8'h00;
    logic lis = 1'b0, tlk = 1'b0, pos = 1'b1, wide = 1'b0, dv_q = 1'b0, tv_q = 1'b0;
    integer seed = 32'h0000_49a2;
    int miscompares = 0, checked = 0, cyc = 0;
    logic [15:0] out_q[$], idy_q[$], tx_q[$];
    wire [7:0] a_i = a_oe ? a_o : p_lines;
    wire [7:0] b_i = b_oe ? b_o : ~b_o;

    always #12.5 clk_sys = ~clk_sys;

    lpp_port_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .loop_cmd(loop_cmd), .loop_rx(loop_rx),
        .loop_tx_r(loop_tx_r), .loop_tx_take(loop_tx_take), .loop_rx_ready_r(rx_rdy), .idy_in(idy_in),
        .idy_out_r(idy_out_r), .srq_out_r(srq), .status_r(status_r), .port_a_lines_i(a_i),
        .port_a_lines_o_r(a_o), .port_a_lines_oe_r(a_oe), .port_b_lines_i(b_i), .port_b_lines_o_r(b_o),
        .port_b_lines_oe_r(b_oe), .data_valid_out_r(dv), .data_accepted_in(acc), .peer_ready_in(rdy),
        .peer_valid_in(pv), .ready_out_r(rdy_o), .accepted_out_r(acc_o), .manual_service_req_n(manual_service_req_n_n),
        .chip_sel_n_r(cs_n));
    lpp_peer peer (.clk_sys(clk_sys), .acc_en(acc_en), .send(send), .send_byte(send_byte), .dv(dv),
        .acc_out(acc_o), .acc_in(acc), .rdy_in(rdy), .val_in(pv), .lines(p_lines));

    task automatic report_and_stop();
        if (miscompares == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] pop(ref logic [15:0] q[$]);
        if (q.size() == 0) return 16'hxxxx;
        return q.pop_front();
    endfunction
    function automatic lpp_loop_cmd_t base();
        base = '0;
        base.listener = lis;
        base.talker = tlk;
    endfunction
    task automatic pulse(input lpp_loop_cmd_t c);
        loop_cmd <= c;
        @(posedge clk_sys);
        loop_cmd <= base();
        @(posedge clk_sys);
    endtask
    task automatic wreg(input logic [4:0] i, input logic [7:0] d);
        lpp_loop_cmd_t c;
        c = base();
        c.reg_wr = 1'b1;
        c.reg_idx = i;
        c.reg_data = d;
        pulse(c);
    endtask
    task automatic ppx(input logic [3:0] i);
        lpp_loop_cmd_t c;
        c = base();
        c.pp_enable = 1'b1;
        c.pp_index = i;
        pulse(c);
    endtask
    task automatic idy(input logic [3:0] pi, input logic en, input logic sv);
        logic [7:0] d;
        d = 8'($random(seed));
        idy_in <= '{valid: 1'b1, srq: 1'b0, data: d};
        idy_q.push_back({7'h00, sv, d | ((en && pi[3] == sv) ? 8'(1 << pi[2:0]) : 8'h00)});
        @(posedge clk_sys);
        idy_in <= '0;
        @(posedge clk_sys);
    endtask
    task automatic push(input logic [7:0] d);
        int n;
        n = 0;
        while (rx_rdy !== 1'b1 && n < 100) begin
            n++;
            @(posedge clk_sys);
        end
        loop_rx <= '{valid: 1'b1, data: d};
        @(posedge clk_sys);
        loop_rx <= '{valid: 1'b0, data: d};
        @(posedge clk_sys);
    endtask
    task automatic out1(input logic [7:0] d);
        out_q.push_back({d, 8'h00});
        push(d);
    endtask
    // valid width in cycles, bounded against a hang
    task automatic width(input int lo, input int hi);
        int n;
        n = 0;
        while (dv !== 1'b1 && n < 500) begin
            n++;
            @(posedge clk_sys);
        end
        n = 0;
        while (dv === 1'b1 && n < 9000) begin
            n++;
            @(posedge clk_sys);
        end
        chk(16'(n >= lo && n <= hi), 16'h0001);
        repeat (4) @(posedge clk_sys);
    endtask

    // scoreboard: each result appearing takes the oldest note of its kind
    always @(posedge clk_sys) begin
        dv_q <= dv;
        tv_q <= loop_tx_r.valid;
        cyc <= cyc + 1;
        if (!rst && pos && dv === 1'b1 && dv_q === 1'b0) chk({a_o, wide ? b_o : 8'h00}, pop(out_q));
        if (!rst && pos && a_oe === 1'b1 && dv === 1'b0) chk(16'(a_o), 16'h00ff);
        if (idy_out_r.valid === 1'b1) chk({7'h00, idy_out_r.srq, idy_out_r.data}, pop(idy_q));
        if (loop_tx_r.valid === 1'b1 && tv_q === 1'b0) chk(16'(loop_tx_r.data), pop(tx_q));
        if (cyc > 30000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        lpp_loop_cmd_t c;
        logic [7:0] d;
        int n;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk({dv, 7'h00, a_o}, 16'h00ff);
        chk(16'(status_r), 16'h0000);
        pos <= 1'b0;
        wreg(REG_BUS_CFG, 8'h10);
        repeat (3) @(posedge clk_sys);
        chk(16'(dv), 16'h0001);
        wreg(REG_BUS_CFG, 8'h00);
        repeat (3) @(posedge clk_sys);
        pos <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            ppx(4'(i));
            idy(4'(i), 1'b1, 1'b0);
        end
        manual_service_req_n_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk(16'({srq, status_r[5:0]}), 16'h0060);
        chk(16'(status_r[ST_SRQ_BIT]), 16'h0001);
        c = base();
        c.send_status = 1'b1;
        pulse(c);
        chk(16'(status_r[ST_SRQ_BIT]), 16'h0000);
        ppx(4'h9);
        idy(4'h9, 1'b1, 1'b1);
        ppx(4'h2);
        idy(4'h2, 1'b1, 1'b1);
        c = base();
        c.pp_unconfig = 1'b1;
        pulse(c);
        idy(4'h9, 1'b0, 1'b1);
        manual_service_req_n_n <= 1'b1;
        lis = 1'b1;
        pulse(base());
        wreg(REG_PULSE_W, 8'h01);
        // slow unit with timeout on: only the two timed modes should honour it
        for (int m = 0; m < 4; m++) begin
            wreg(REG_BUS_CFG, 8'(m << 6) | 8'h01);
            out1(8'($random(seed)));
            width(m < 2 ? 190 : 3990, m < 2 ? 410 : 8010);
            if (m > 1) chk(16'(status_r[5:0]), 16'(ST_NO_HS));
        end
        wreg(REG_BUS_CFG, 8'hc9);
        out1(8'($random(seed)));
        width(190, 410);
        acc_en <= 1'b1;
        out1(8'($random(seed)));
        width(1, 40);
        wreg(REG_BUS_CFG, 8'h04);
        wide <= 1'b1;
        d = 8'($random(seed));
        out_q.push_back({d, ~d});
        push(d);
        push(~d);
        width(190, 410);
        wide <= 1'b0;
        acc_en <= 1'b0;
        wreg(REG_BUS_CFG, 8'hc0);
        out1(8'($random(seed)));
        out1(8'($random(seed)));
        repeat (10) @(posedge clk_sys);
        send_byte <= 8'($random(seed));
        send <= 1'b1;
        repeat (10) @(posedge clk_sys);
        chk(16'(status_r[5:0]), 16'(ST_BUSY));
        send <= 1'b0;
        acc_en <= 1'b1;
        repeat (20) @(posedge clk_sys);
        chk(16'(status_r[5:0]), 16'(ST_BUSY));
        c = base();
        c.send_status = 1'b1;
        pulse(c);
        lis = 1'b0;
        tlk = 1'b1;
        wreg(REG_BUS_CFG, 8'h00);
        d = 8'($random(seed));
        tx_q.push_back({8'h00, d});
        send_byte <= d;
        send <= 1'b1;
        n = 0;
        while (loop_tx_r.valid !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk_sys);
        end
        chk(16'({a_oe, status_r[5:0]}), 16'(ST_DATA_LOOP));
        loop_tx_take <= 1'b1;
        @(posedge clk_sys);
        loop_tx_take <= 1'b0;
        send <= 1'b0;
        repeat (5) @(posedge clk_sys);
        report_and_stop();
    end
endmodule
